// [tpr_regs.sv]
// Programming register bank of the trace unit: configuration,
// counters, event selection, affinity and identification.
// Assumes the debug access port and core signals share MCLK.
`timescale 1ns/10ps

module tpr_regs
	import tpr_pkg::*;
#(
	parameter logic        VCTX_SRC_IMPL = 1'b1,
	parameter logic [10:0] ARCHITECT     = 11'h2a5, // Arbitrary value.
	parameter logic [3:0]  ARCH_REV      = 4'h1,    // Arbitrary value.
	parameter logic [15:0] ARCH_ID       = 16'h5c21 // Arbitrary value.
)
(
	// Clock and reset
	input  wire logic         MCLK,
	input  wire logic         RST,
	// Debug access port
	input  wire tpr_dbg_req_t DBG_REQ,
	output logic      [31:0]  DBG_RDATA,
	output logic              DBG_RVALID,
	// Resource selector terms
	input  wire logic [15:0]  RES_SINGLE,
	input  wire logic [7:0]   RES_PAIR,
	// Core identity and context inputs
	input  wire logic [63:0]  MPAFF,
	input  wire logic [15:0]  STAGE2_VMID,
	input  wire logic         VMID_8BIT,
	input  wire logic [31:0]  HYP_CTX_ID,
	// Trace generation controls
	output tpr_cfg_t          CFG_OUT,
	output logic      [31:0]  VCTX_ID,
	output logic [EV_N-1:0]   EVENT_OUT
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		tpr_cfg_t               cfg;
		tpr_evsel_t [EV_N-1:0]  evsel;
		tpr_cctl_t              cctl0;
		tpr_cctl_t              cctl1;
		logic [CNT_W-1:0]       rld0;
		logic [CNT_W-1:0]       rld1;
		logic [31:0]            rdata;
		logic                   rvalid;
		logic [31:0]            vctx;
	} tpr_regs_st_t;

	tpr_regs_st_t     st_r;
	tpr_regs_st_t     st_nxt;
	logic             wr_req;
	logic             rd_req;
	logic             c0_cnt;
	logic             c0_rld;
	logic             c0_reload;
	logic             c1_cnt;
	logic             c1_rld;
	logic             c1_chain;
	logic [CNT_W-1:0] c0_val;
	logic [CNT_W-1:0] c1_val;
	logic [31:0]      arch_word;
	logic [31:0]      type_word;

	assign wr_req = DBG_REQ.sel & DBG_REQ.wr;
	assign rd_req = DBG_REQ.sel & ~DBG_REQ.wr;

	// Fixed identification words.
	assign arch_word = {ARCHITECT, 1'b1, ARCH_REV, ARCH_ID};
	assign type_word = 32'({TYPE_SUB, TYPE_MAJOR});

	// ------------------------------------------------------------
	// Counter resource decode
	// ------------------------------------------------------------

	// Count and reload terms of the first counter.
	assign c0_cnt = res_pick(st_r.cctl0.count_resource_kind,
		st_r.cctl0.count_resource_number, RES_SINGLE, RES_PAIR);
	assign c0_rld = res_pick(st_r.cctl0.reload_resource_kind,
		st_r.cctl0.reload_resource_number, RES_SINGLE, RES_PAIR);

	// The second counter reads four bits or three by its kind bit.
	assign c1_cnt = res_pick(st_r.cctl1.count_resource_kind,
		st_r.cctl1.count_resource_number,
		RES_SINGLE, RES_PAIR);
	assign c1_rld = res_pick(st_r.cctl1.reload_resource_kind,
		st_r.cctl1.reload_resource_number, RES_SINGLE, RES_PAIR);

	// Chaining turns the pair into one longer counter.
	assign c1_chain = st_r.cctl1.chain_to_neighbour_counter
		& c0_reload;

	// First counter.
	tpr_counter u_cnt0
	(
		.clk       (MCLK),
		.rst       (RST),
		.cnt_act   (c0_cnt),
		.chain_dec (1'b0),
		.rld_act   (c0_rld),
		.self_rld  (st_r.cctl0.self_reload_at_zero),
		.rld_val   (st_r.rld0),
		.wr_en     (wr_req && DBG_REQ.addr == OFF_CNT0),
		.wr_val    (DBG_REQ.wdata[CNT_W-1:0]),
		.value     (c0_val),
		.reload    (c0_reload)
	);

	// Second counter.
	tpr_counter u_cnt1
	(
		.clk       (MCLK),
		.rst       (RST),
		.cnt_act   (c1_cnt),
		.chain_dec (c1_chain),
		.rld_act   (c1_rld),
		.self_rld  (st_r.cctl1.self_reload_at_zero),
		.rld_val   (st_r.rld1),
		.wr_en     (wr_req && DBG_REQ.addr == OFF_CNT1),
		.wr_val    (DBG_REQ.wdata[CNT_W-1:0]),
		.value     (c1_val),
		.reload    ()
	);

	// Event selectors.
	tpr_events u_events
	(
		.clk        (MCLK),
		.rst        (RST),
		.evsel      (st_r.evsel),
		.res_single (RES_SINGLE),
		.res_pair   (RES_PAIR),
		.events     (EVENT_OUT)
	);

	// ------------------------------------------------------------
	// Register writes, read mux and context value
	// ------------------------------------------------------------

	// Writes land at the request edge; reads answer one cycle later.
	always_comb
	begin
		tpr_cfg_t cfg_w;
		cfg_w  = tpr_cfg_t'((DBG_REQ.wdata & CFG_WMASK)
			| CFG_RES1);
		st_nxt = st_r;
		st_nxt.rvalid = rd_req;

		// Reserved Q element code leaves the field as it was.
		if (cfg_w.q_element_enable == QE_RSVD)
			cfg_w.q_element_enable = st_r.cfg.q_element_enable;
		if (!VCTX_SRC_IMPL)
			cfg_w.virtual_context_source = 1'b0;

		if (wr_req)
		begin
			unique case (DBG_REQ.addr)
				// Masking keeps reserved and read-as-zero bits at zero, except configuration bit zero, which is forced to one.
				OFF_CONFIG: st_nxt.cfg = cfg_w;
				OFF_EVSEL:
					st_nxt.evsel = DBG_REQ.wdata & EVSEL_WMASK;
				OFF_CCTL0:
					st_nxt.cctl0 = DBG_REQ.wdata & CCTL0_WMASK;
				OFF_CCTL1:
					st_nxt.cctl1 = DBG_REQ.wdata & CCTL1_WMASK;
				OFF_RLD0: st_nxt.rld0 = DBG_REQ.wdata[CNT_W-1:0];
				OFF_RLD1: st_nxt.rld1 = DBG_REQ.wdata[CNT_W-1:0];
				// Identification and affinity writes are dropped.
				default:  st_nxt = st_nxt;
			endcase
		end

		if (rd_req)
		begin
			unique case (DBG_REQ.addr)
				OFF_CONFIG: st_nxt.rdata = st_r.cfg;
				OFF_EVSEL:  st_nxt.rdata = st_r.evsel;
				OFF_CCTL0:  st_nxt.rdata = st_r.cctl0;
				OFF_CCTL1:  st_nxt.rdata = st_r.cctl1;
				OFF_RLD0:   st_nxt.rdata = 32'(st_r.rld0);
				OFF_RLD1:   st_nxt.rdata = 32'(st_r.rld1);
				OFF_CNT0:   st_nxt.rdata = 32'(c0_val);
				OFF_CNT1:   st_nxt.rdata = 32'(c1_val);
				OFF_AFF_LO: st_nxt.rdata = MPAFF[31:0];
				OFF_AFF_HI: st_nxt.rdata = MPAFF[63:32];
				OFF_ARCH:   st_nxt.rdata = arch_word;
				OFF_CAPS:   st_nxt.rdata = CAPS_VALUE;
				OFF_TYPE:   st_nxt.rdata = type_word;
				default:    st_nxt.rdata = '0;
			endcase
		end

		// Virtual context value handed to trace generation.
		if (st_r.cfg.virtual_context_source)
			st_nxt.vctx = HYP_CTX_ID;
		else if (VMID_8BIT)
			st_nxt.vctx = 32'(STAGE2_VMID[7:0]);
		else
			st_nxt.vctx = 32'(STAGE2_VMID);
	end

	// State register; configuration resets with its fixed one bit.
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			st_r     <= '0;
			st_r.cfg <= tpr_cfg_t'(CFG_RES1);
		end
		else
			st_r <= st_nxt;
	end

	// Controls reach trace generation straight from flip-flops.
	assign CFG_OUT    = st_r.cfg;
	assign VCTX_ID    = st_r.vctx;
	assign DBG_RDATA  = st_r.rdata;
	assign DBG_RVALID = st_r.rvalid;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	property p_cfg_raz;
		rd_req && DBG_REQ.addr == OFF_CONFIG |=> DBG_RVALID
			&& DBG_RDATA[17:16] == 2'h0 && DBG_RDATA[0] && !DBG_RDATA[5];
	endproperty
	a_cfg_raz: assert property (p_cfg_raz)
		else $error("Configuration read shows bad fixed bits.");

	property p_type_read;
		rd_req && DBG_REQ.addr == OFF_TYPE
			|=> DBG_RDATA == 32'h00000013;
	endproperty
	a_type_read: assert property (p_type_read)
		else $error("Type register reads a wrong value.");

	property p_caps_read;
		rd_req && DBG_REQ.addr == OFF_CAPS |=> DBG_RDATA == 32'h0;
	endproperty
	a_caps_read: assert property (p_caps_read)
		else $error("Capabilities register is not zero.");

	property p_arch_read;
		rd_req && DBG_REQ.addr == OFF_ARCH
			|=> DBG_RDATA[20] && DBG_RDATA[15:0] == ARCH_ID;
	endproperty
	a_arch_read: assert property (p_arch_read)
		else $error("Architecture register fields are wrong.");

	property p_aff_mirror;
		rd_req && DBG_REQ.addr == OFF_AFF_LO
			|=> DBG_RDATA == $past(MPAFF[31:0]);
	endproperty
	a_aff_mirror: assert property (p_aff_mirror)
		else $error("Affinity low does not mirror the core.");

	property p_aff_high;
		rd_req && DBG_REQ.addr == OFF_AFF_HI
			|=> DBG_RDATA == $past(MPAFF[63:32]);
	endproperty
	a_aff_high: assert property (p_aff_high)
		else $error("Affinity high does not mirror the core.");

	property p_vmid_8bit;
		!st_r.cfg.virtual_context_source && VMID_8BIT
			|=> VCTX_ID[31:8] == 24'h0;
	endproperty
	a_vmid_8bit: assert property (p_vmid_8bit)
		else $error("Forced short identifier has upper bits set.");

	property p_hyp_ctx;
		st_r.cfg.virtual_context_source |=> VCTX_ID == $past(HYP_CTX_ID);
	endproperty
	a_hyp_ctx: assert property (p_hyp_ctx)
		else $error("Hypervisor context is not used as source.");

	property p_qe_rsvd;
		wr_req && DBG_REQ.addr == OFF_CONFIG
			&& DBG_REQ.wdata[14:13] == QE_RSVD
			|=> $stable(CFG_OUT.q_element_enable);
	endproperty
	a_qe_rsvd: assert property (p_qe_rsvd)
		else $error("Reserved Q element code was stored.");

	property p_ro_write;
		wr_req && DBG_REQ.addr == OFF_ARCH |=> $stable(CFG_OUT)
			&& $stable(st_r.evsel) && $stable(st_r.rld0);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("Write to read-only register changed state.");

	property p_cnt_read;
		rd_req && DBG_REQ.addr == OFF_CNT1
			|=> DBG_RDATA == 32'($past(c1_val));
	endproperty
	a_cnt_read: assert property (p_cnt_read)
		else $error("Counter value read does not match counter.");

	property p_rvalid_pulse;
		1'b1 |=> DBG_RVALID == $past(rd_req);
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse)
		else $error("Read answer pulse does not follow the read.");

	property p_cnt0_read;
		rd_req && DBG_REQ.addr == OFF_CNT0
			|=> DBG_RDATA == 32'($past(c0_val));
	endproperty
	a_cnt0_read: assert property (p_cnt0_read)
		else $error("Counter zero read does not match counter.");

	property p_cctl_raz;
		rd_req && DBG_REQ.addr == OFF_CCTL1
			|=> (DBG_RDATA & ~CCTL1_WMASK) == 32'h0;
	endproperty
	a_cctl_raz: assert property (p_cctl_raz)
		else $error("Counter control reserved bits read nonzero.");

	property p_evsel_raz;
		rd_req && DBG_REQ.addr == OFF_EVSEL
			|=> (DBG_RDATA & ~EVSEL_WMASK) == 32'h0;
	endproperty
	a_evsel_raz: assert property (p_evsel_raz)
		else $error("Event select reserved bits read nonzero.");

	property p_vmid_full;
		!st_r.cfg.virtual_context_source && !VMID_8BIT
			|=> VCTX_ID == 32'($past(STAGE2_VMID));
	endproperty
	a_vmid_full: assert property (p_vmid_full)
		else $error("Stage two identifier is not used as source.");

	property p_chain_dec;
		c1_chain && !c1_rld && c1_val != '0
			&& !(wr_req && DBG_REQ.addr == OFF_CNT1)
			|=> c1_val == $past(c1_val) - 1'b1;
	endproperty
	a_chain_dec: assert property (p_chain_dec)
		else $error("Chained counter did not step on first reload.");

	property p_qe_store;
		wr_req && DBG_REQ.addr == OFF_CONFIG
			&& DBG_REQ.wdata[14:13] != QE_RSVD
			|=> CFG_OUT.q_element_enable == $past(DBG_REQ.wdata[14:13]);
	endproperty
	a_qe_store: assert property (p_qe_store)
		else $error("Legal Q element code was not stored.");

endmodule : tpr_regs

// [tpr_pkg.sv]
// Shared constants, register layouts and types for the trace unit
// programming register block.
// Assumes one core clock and a debug access port on the same clock.
//
// What this block does
// - Second counter resource number decoded by kind.
// - Self reload at zero while count resource active.
// - Chained second counter decrements on first reload.
// - Reload values are 16 bits, loaded on reload.
// - Counter value reads 16 bits, upper bits zero.
// - Value and address trace bits read zero.
// - Source zero uses stage two identifier, zero padded.
// - Source one uses hypervisor context identifier.
// - Q element field; code two is reserved.
// - Bit twelve enables the return stack.
// - Bit eleven enables global timestamp tracing.
// - Conditional trace field selects traced conditionals.
// - Bit seven enables virtual machine identifier tracing.
// - Bit six enables context tracing; bit five reserved.
// - Bit four enables cycle counting trace.
// - Bit three enables branch broadcast mode.
// - Memory op element select; bit zero reads one.
// - Affinity low mirrors core affinity bits low.
// - Affinity high mirrors upper bits, never virtualised.
// - Architecture register reports four read-only fields.
// - Capabilities register reads all zero.
// - Type register reads core trace, trace source.
// - Four selected events drive trace and outputs.
// - Event control holds kind bit and select.
// - Event select picks single or combined pair.

package tpr_pkg;

	// ------------------------------------------------------------
	// Sizes and register offsets
	// ------------------------------------------------------------
	localparam int          CNT_W       = 16;
	localparam int          ADDR_W      = 12;
	localparam int          EV_N        = 4;
	localparam logic [11:0] OFF_CONFIG  = 12'h010;
	localparam logic [11:0] OFF_EVSEL   = 12'h020;
	localparam logic [11:0] OFF_RLD0    = 12'h140;
	localparam logic [11:0] OFF_RLD1    = 12'h144;
	localparam logic [11:0] OFF_CCTL0   = 12'h150;
	localparam logic [11:0] OFF_CCTL1   = 12'h154;
	localparam logic [11:0] OFF_CNT0    = 12'h160;
	localparam logic [11:0] OFF_CNT1    = 12'h164;
	localparam logic [11:0] OFF_AFF_LO  = 12'hfa8;
	localparam logic [11:0] OFF_AFF_HI  = 12'hfac;
	localparam logic [11:0] OFF_ARCH    = 12'hfbc;
	localparam logic [11:0] OFF_CAPS    = 12'hfc8;
	localparam logic [11:0] OFF_TYPE    = 12'hfcc;

	// ------------------------------------------------------------
	// Write masks, reset values and fixed codes
	// ------------------------------------------------------------
	localparam logic [31:0] CFG_WMASK   = 32'h0000ffde;
	localparam logic [31:0] CFG_RES1    = 32'h00000001;
	localparam logic [31:0] CCTL0_WMASK = 32'h00018f8f;
	localparam logic [31:0] CCTL1_WMASK = 32'h00038f8f;
	localparam logic [31:0] EVSEL_WMASK = 32'h8f8f8f8f;
	localparam logic [1:0]  QE_RSVD     = 2'h2;
	localparam logic [3:0]  TYPE_SUB    = 4'h1;
	localparam logic [3:0]  TYPE_MAJOR  = 4'h3;
	localparam logic [31:0] CAPS_VALUE  = 32'h00000000;

	// ------------------------------------------------------------
	// Register layouts and request carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic [13:0] rsvd_hi;
		logic        value_trace_enable;
		logic        address_trace_enable;
		logic        virtual_context_source;
		logic [1:0]  q_element_enable;
		logic        return_stack_enable;
		logic        timestamp_enable;
		logic [2:0]  conditional_trace_select;
		logic        vmid_trace_enable;
		logic        context_trace_enable;
		logic        rsvd_5;
		logic        cycle_count_enable;
		logic        branch_broadcast_enable;
		logic [1:0]  memory_op_element_select;
		logic        rsvd_one;
	} tpr_cfg_t;

	typedef struct packed {
		logic [13:0] rsvd_hi;
		logic        chain_to_neighbour_counter;
		logic        self_reload_at_zero;
		logic        reload_resource_kind;
		logic [2:0]  rsvd_b;
		logic [3:0]  reload_resource_number;
		logic        count_resource_kind;
		logic [2:0]  rsvd_c;
		logic [3:0]  count_resource_number;
	} tpr_cctl_t;

	typedef struct packed {
		logic       resource_kind;
		logic [2:0] rsvd;
		logic [3:0] resource_number;
	} tpr_evsel_t;

	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} tpr_dbg_req_t;

	// Picks a single resource (0-15) or a combined pair (0-7).
	function automatic logic res_pick(input logic kind,
		input logic [3:0] num, input logic [15:0] single,
		input logic [7:0] pair);
		logic hit;
		hit = kind ? pair[num[2:0]] : single[num];
		return hit;
	endfunction : res_pick

endpackage : tpr_pkg

// [tpr_counter.sv]
// One 16-bit resource-driven down counter with reload.
// Assumes enables arrive from logic on the same clock.
`timescale 1ns/10ps

module tpr_counter
	import tpr_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Resource terms
	input  wire logic             cnt_act,
	input  wire logic             chain_dec,
	input  wire logic             rld_act,
	input  wire logic             self_rld,
	input  wire logic [CNT_W-1:0] rld_val,
	// Debugger write
	input  wire logic             wr_en,
	input  wire logic [CNT_W-1:0] wr_val,
	// Results
	output logic      [CNT_W-1:0] value,
	output logic                  reload
);

	typedef struct packed {
		logic [CNT_W-1:0] val;
	} tpr_cnt_st_t;

	tpr_cnt_st_t st_r;
	tpr_cnt_st_t st_nxt;
	logic        zero;

	// ------------------------------------------------------------
	// Reload and decrement
	// ------------------------------------------------------------

	// Self reload fires only at zero with the count resource active.
	assign zero   = (st_r.val == '0);
	assign reload = rld_act | (self_rld & cnt_act & zero);
	assign value  = st_r.val;

	// A debugger write wins, then a reload, then a decrement.
	always_comb
	begin
		st_nxt = st_r;
		if (wr_en)
			st_nxt.val = wr_val;
		else if (reload)
			st_nxt.val = rld_val;
		else if ((cnt_act | chain_dec) && !zero)
			st_nxt.val = st_r.val - 1'b1;
	end

	// State register.
	always_ff @(posedge clk)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// A reload without a write loads the reload value.
	property p_reload_loads;
		@(posedge clk) disable iff (rst)
		reload && !wr_en |=> st_r.val == $past(rld_val);
	endproperty
	a_reload_loads: assert property (p_reload_loads)
		else $error("Counter did not take the reload value.");

	// At zero with self reload and an active resource, it reloads.
	property p_self_reload;
		@(posedge clk) disable iff (rst)
		zero && self_rld && cnt_act && !wr_en
			|=> st_r.val == $past(rld_val);
	endproperty
	a_self_reload: assert property (p_self_reload)
		else $error("Counter missed a self reload at zero.");

endmodule : tpr_counter

// [tpr_events.sv]
// Four trace event selectors driven from the resource selectors.
// Assumes resource terms come from logic on the same clock.
`timescale 1ns/10ps

module tpr_events
	import tpr_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Selection and resources
	input  wire tpr_evsel_t [EV_N-1:0] evsel,
	input  wire logic      [15:0]      res_single,
	input  wire logic      [7:0]       res_pair,
	// Registered events
	output logic           [EV_N-1:0]  events
);

	typedef struct packed {
		logic [EV_N-1:0] ev;
	} tpr_ev_st_t;

	tpr_ev_st_t      st_r;
	tpr_ev_st_t      st_nxt;
	logic [EV_N-1:0] hit;

	// ------------------------------------------------------------
	// Per-event resource pick
	// ------------------------------------------------------------
	for (genvar i = 0; i < EV_N; i++)
	begin : g_ev
		assign hit[i] = res_pick(evsel[i].resource_kind,
			evsel[i].resource_number, res_single, res_pair);
	end

	// Events are registered so the outputs leave a flip-flop.
	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.ev = hit;
	end

	// State register.
	always_ff @(posedge clk)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign events = st_r.ev;

	// Event zero follows its selected resource one cycle later.
	property p_ev0_follows;
		@(posedge clk) disable iff (rst)
		1'b1 |=> events[0] == $past(res_pick(evsel[0].resource_kind,
			evsel[0].resource_number, res_single, res_pair));
	endproperty
	a_ev0_follows: assert property (p_ev0_follows)
		else $error("Event zero does not follow its resource.");

endmodule : tpr_events

// [tpr_dbg_model.sv]
// Debugger model that issues register reads and writes on the port.
// Assumes one request per call and the answer one cycle after the take.
`timescale 1ns/10ps

module tpr_dbg_model
	import tpr_pkg::*;
(
	// Clock
	input  wire logic        MCLK,
	// Register port
	output tpr_dbg_req_t     DBG_REQ,
	input  wire logic [31:0] DBG_RDATA,
	input  wire logic        DBG_RVALID
);
	// The port is idle from time zero.
	initial DBG_REQ = '0;

	// Presents one request for one taking edge, then releases the lines.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge MCLK);
		#1;
		DBG_REQ = '{sel: 1'b1, wr: w, addr: a, wdata: d};
		@(posedge MCLK);
		#1;
		// Released lines show the inverse so stale values cannot match.
		DBG_REQ = '{sel: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
	endtask : xfer

	// Reads a word; a missing answer pulse yields unknown data.
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h0);
		d = (DBG_RVALID === 1'b1) ? DBG_RDATA : 'x;
	endtask : rd
endmodule : tpr_dbg_model

// [trace_unit_programming_regs_test.sv]
// Self-checking bench for the trace unit programming registers.
// Assumes the debugger model drives the port; the bench drives core inputs.
`timescale 1ns/10ps

`define chk(g, e) begin comparisons++; if ((g) !== (e)) begin \
	mismatches++; $display("unexpected at %0t: got %h want %h", \
	$time, g, e); end end

module trace_unit_programming_regs_test;
	import tpr_pkg::*;

	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	localparam logic [10:0] ARCHITECT_V = 11'h2a5; // Arbitrary value.
	localparam logic [3:0]  ARCH_REV_V  = 4'h1;    // Arbitrary value.
	localparam logic [15:0] ARCH_ID_V   = 16'h5c21; // Arbitrary value.
	logic         mclk;
	logic         rst;
	tpr_dbg_req_t req;
	logic [31:0]  rdata;
	logic         rvalid;
	logic [15:0]  res_single;
	logic [7:0]   res_pair;
	logic [63:0]  mpaff;
	logic [15:0]  vmid;
	logic         vmid8;
	logic [31:0]  hyp;
	tpr_cfg_t     cfg_out;
	logic [31:0]  vctx;
	logic [3:0]   ev;
	int           mismatches;
	int           comparisons;
	int           cycles;

	tpr_regs #(.ARCHITECT(ARCHITECT_V), .ARCH_REV(ARCH_REV_V),
		.ARCH_ID(ARCH_ID_V)) i_tpr_regs (.MCLK(mclk), .RST(rst),
		.DBG_REQ(req), .DBG_RDATA(rdata), .DBG_RVALID(rvalid),
		.RES_SINGLE(res_single), .RES_PAIR(res_pair), .MPAFF(mpaff),
		.STAGE2_VMID(vmid), .VMID_8BIT(vmid8), .HYP_CTX_ID(hyp),
		.CFG_OUT(cfg_out), .VCTX_ID(vctx), .EVENT_OUT(ev));

	tpr_dbg_model i_tpr_dbg_model (.MCLK(mclk), .DBG_REQ(req),
		.DBG_RDATA(rdata), .DBG_RVALID(rvalid));

	// ----------------------------------------------------------------
	// Clock, timeout and closing report
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Cuts a hang short well beyond the expected run of under two hundred cycles.
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// Access helpers
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_tpr_dbg_model.xfer(1'b1, a, d);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] got;
		i_tpr_dbg_model.rd(a, got);
		`chk(got, e)
	endtask : rd_chk

	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : hold

	// Holds the given resource terms active for n sampling edges.
	task automatic pulse(input logic [15:0] s, input logic [7:0] p,
		input int n);
		res_single = s;
		res_pair = p;
		hold(n);
		res_single = '0;
		res_pair = '0;
	endtask : pulse

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin : main
		logic [31:0] cv [17];
		logic [31:0] cur;
		logic [11:0] ida [6];
		logic [31:0] ide [6];
		{rst, res_single, res_pair, vmid8} = {1'b1, 16'h0, 8'h0, 1'b0};
		{mpaff, vmid, hyp} = {64'h0123456789abcdef, 16'habcd, 32'h89abcdef};
		{mismatches, comparisons, cycles} = 0;
		hold(10);
		rst = 1'b0;
		`chk(cfg_out, 32'h1)
		// Identification, affinity and unmapped places ignore writes.
		ida = '{OFF_ARCH, OFF_CAPS, OFF_TYPE, OFF_AFF_LO, OFF_AFF_HI, 12'h030};
		ide = '{{ARCHITECT_V, 1'b1, ARCH_REV_V, ARCH_ID_V}, CAPS_VALUE,
			{24'h0, TYPE_SUB, TYPE_MAJOR}, mpaff[31:0], mpaff[63:32], 32'h0};
		foreach (ida[i])
		begin
			wr(ida[i], 32'hffffffff);
			rd_chk(ida[i], ide[i]);
		end
		// All bits at once, then each field in bits 14 to 1, with some field codes, in turn.
		cv = '{32'hffffffff, 32'h4000, 32'h1000, 32'h0800, 32'h0100,
			32'h0200, 32'h0300, 32'h0700, 32'h0080, 32'h0040, 32'h0010,
			32'h0008, 32'h0002, 32'h0004, 32'h0006, 32'h0020, 32'h0};
		cur = 32'h1;
		foreach (cv[i])
		begin
			if (cv[i][14:13] == 2'b10)
				cur = ((cv[i] & CFG_WMASK) & ~32'h6000) | (cur & 32'h6000) | 1;
			else
				cur = (cv[i] & CFG_WMASK) | 32'h1;
			wr(OFF_CONFIG, cv[i]);
			rd_chk(OFF_CONFIG, cur);
			`chk(cfg_out, cur)
		end
		// Virtual context value source and width.
		hold(2);
		`chk(vctx, 32'h0000abcd)
		vmid8 = 1'b1;
		hold(2);
		`chk(vctx, 32'h000000cd)
		wr(OFF_CONFIG, 32'h8000);
		hold(2);
		`chk(vctx, hyp)
		// Counter zero: reload value, count down and self reload.
		wr(OFF_RLD0, 32'h12345678);
		rd_chk(OFF_RLD0, 32'h5678);
		wr(OFF_CNT0, 32'hffff0003);
		rd_chk(OFF_CNT0, 32'h3);
		wr(OFF_CCTL0, 32'h00010205);
		pulse(16'h0020, 8'h0, 3);
		rd_chk(OFF_CNT0, 32'h0);
		pulse(16'h0020, 8'h0, 1);
		rd_chk(OFF_CNT0, 32'h5678);
		// Counter one: chained to reload of counter zero, pair selection.
		wr(OFF_CNT0, 32'h7);
		wr(OFF_CNT1, 32'ha);
		wr(OFF_CCTL1, 32'h0002008a);
		pulse(16'h0004, 8'h0, 1);
		rd_chk(OFF_CNT0, 32'h5678);
		rd_chk(OFF_CNT1, 32'h9);
		pulse(16'h0400, 8'h0, 1);
		rd_chk(OFF_CNT1, 32'h9);
		pulse(16'h0, 8'h04, 1);
		rd_chk(OFF_CNT1, 32'h8);
		// Event selection by kind and number.
		wr(OFF_EVSEL, 32'hfa73f17f);
		rd_chk(OFF_EVSEL, 32'h8a03810f);
		res_single = 16'h8008;
		res_pair = 8'h06;
		hold(2);
		`chk(ev, 4'hf)
		res_single = 16'h0400;
		res_pair = 8'h0;
		hold(2);
		`chk(ev, 4'h0)
		res_pair = 8'h04;
		hold(2);
		`chk(ev, 4'h8)
		stop_test();
	end
endmodule : trace_unit_programming_regs_test
